// ---- verilog/prescaled_timer_counter.sv ----
// Prescaled 16-bit timer/counter with AXI4-Lite register access
// Summary of operation
// - System clock source advances the count every clock, four per instruction cycle
// - Counter mode needs a falling edge before the first counted rising edge
// - Disable while input high then enable while low still waits for fall
// - External clock source works as timer or as event counter
// - External source counts rising edges of the pin chosen by pin select
// - External clock may take an extra system-clock alignment stage or skip it; both paths pass the two-flop synchroniser
// - Selected count clock is divided by 1, 2, 4 or 8
// - Software cannot read or write the prescale divider count
// - Writing either count byte clears the prescale divider
// - Secondary oscillator is a count source and shared with other modules
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module prescaled_timer_counter (
  // Clock and reset
  input  wire logic                                  clock_i,
  input  wire logic                                  resetn_i,
  // Count inputs from pins
  input  wire logic [timer_pkg::PIN_COUNT-1:0]       ext_count_input_i,
  input  wire logic                                  secondary_osc_in_i,
  // Shared clock and counter state
  output logic                                       secondary_osc_clk_o,
  output logic      [timer_pkg::COUNT_W-1:0]         count_value_o,
  // AXI4-Lite write address
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [timer_pkg::ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic [2:0]                            s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  input  wire logic [timer_pkg::DATA_W-1:0]          s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  output logic      [1:0]                            s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  input  wire logic [timer_pkg::ADDR_W-1:0]          s_axi_araddr,
  input  wire logic [2:0]                            s_axi_arprot,
  // AXI4-Lite read data
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output logic      [timer_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic      [1:0]                            s_axi_rresp
);
  // Reset release synchroniser
  logic                                 rst_meta;
  logic                                 rst_n;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Control state
  logic                                 timer_on_bit;
  timer_pkg::source_t                   count_source;
  logic [timer_pkg::PS_SEL_W-1:0]       prescale_select;
  logic                                 ext_sync_en;
  logic [timer_pkg::PIN_SEL_W-1:0]      ext_count_pin_select;
  logic [timer_pkg::COUNT_W-1:0]        count;
  logic                                 armed;
  logic [1:0]                           instr_phase;
  logic                                 level_aligned;
  logic                                 level_prev;

  // Synchronised pins, secondary oscillator in the top bit
  logic [timer_pkg::PIN_COUNT:0]        pins_sync;

  bit_sync #(
    .WIDTH (timer_pkg::PIN_COUNT + 1)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .d_i     ({secondary_osc_in_i, ext_count_input_i}),
    .q_o     (pins_sync)
  );

  // Source level selection and edge detection
  wire        pin_level   = pins_sync[ext_count_pin_select];
  wire        sec_level   = pins_sync[timer_pkg::PIN_COUNT];
  wire        edge_source = (count_source == timer_pkg::SRC_PIN) ||
                            (count_source == timer_pkg::SRC_SEC);
  wire        raw_level   = (count_source == timer_pkg::SRC_SEC) ? sec_level : pin_level;
  // Synchronised mode adds one system-clock alignment stage
  wire        src_level   = ext_sync_en ? level_aligned : raw_level;
  wire        src_rise    = src_level && !level_prev;
  wire        src_fall    = !src_level && level_prev;

  // AXI write channel state
  logic                                 aw_held;
  logic                                 w_held;
  logic [timer_pkg::ADDR_W-1:0]         aw_addr;
  logic [timer_pkg::DATA_W-1:0]         w_data;
  logic [3:0]                           w_strb;

  wire        do_write    = aw_held && w_held && !s_axi_bvalid;
  wire        wr_ctrl     = do_write && (aw_addr == timer_pkg::OFS_CTRL);
  wire        wr_lo       = do_write && (aw_addr == timer_pkg::OFS_COUNT_LO) && w_strb[0];
  wire        wr_hi       = do_write && (aw_addr == timer_pkg::OFS_COUNT_HI) && w_strb[0];
  wire        count_wr    = wr_lo || wr_hi;
  // Only the four registers decode; the prescale count has no address
  wire        wr_mapped   = (aw_addr == timer_pkg::OFS_CTRL) ||
                            (aw_addr == timer_pkg::OFS_COUNT_LO) ||
                            (aw_addr == timer_pkg::OFS_COUNT_HI) ||
                            (aw_addr == timer_pkg::OFS_STATUS);

  // Raw tick before division
  wire        instr_tick  = (instr_phase == timer_pkg::INSTR_LAST);
  wire        raw_tick    = timer_on_bit && (
                  (count_source == timer_pkg::SRC_SYS) ||
                  ((count_source == timer_pkg::SRC_INSTR) && instr_tick) ||
                  (edge_source && armed && src_rise));

  count_if psif ();

  assign psif.tick   = raw_tick;
  assign psif.clear  = count_wr || !timer_on_bit;
  assign psif.select = prescale_select;

  count_prescaler u_prescaler (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .ps      (psif.feeder)
  );

  wire        inc         = psif.tick_out;
  // Byte writes take priority over a same-cycle increment
  wire [15:0] next_count  = wr_lo ? {count[15:8], w_data[7:0]} :
                            wr_hi ? {w_data[7:0], count[7:0]} :
                            inc   ? count + 16'h0001 : count;

  // A falling edge arms counting; disable or a count write disarms it
  wire        next_armed  = (!timer_on_bit || count_wr) ? 1'b0 :
                            src_fall ? 1'b1 : armed;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_on_bit         <= timer_pkg::CTRL_RESET[timer_pkg::CTRL_ON_BIT];
      count_source         <= timer_pkg::SRC_SYS;
      prescale_select      <= '0;
      ext_sync_en          <= 1'b0;
      ext_count_pin_select <= '0;
    end else if (wr_ctrl && w_strb[0]) begin
      timer_on_bit         <= w_data[timer_pkg::CTRL_ON_BIT];
      count_source         <= timer_pkg::source_t'(w_data[timer_pkg::CTRL_SRC_LSB +: 2]);
      prescale_select      <= w_data[timer_pkg::CTRL_PS_LSB +: timer_pkg::PS_SEL_W];
      ext_sync_en          <= w_data[timer_pkg::CTRL_SYNC_BIT];
      if (w_strb[1]) begin
        ext_count_pin_select <= w_data[timer_pkg::CTRL_PIN_LSB +: timer_pkg::PIN_SEL_W];
      end
    end else if (wr_ctrl && w_strb[1]) begin
      ext_count_pin_select <= w_data[timer_pkg::CTRL_PIN_LSB +: timer_pkg::PIN_SEL_W];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      count         <= timer_pkg::COUNT_RESET;
      armed         <= 1'b0;
      instr_phase   <= 2'h0;
      level_aligned <= 1'b0;
      level_prev    <= 1'b0;
    end else begin
      count         <= next_count;
      armed         <= next_armed;
      instr_phase   <= timer_on_bit ? instr_phase + 2'h1 : 2'h0;
      level_aligned <= raw_level;
      level_prev    <= src_level;
    end
  end

  assign count_value_o       = count;
  assign secondary_osc_clk_o = sec_level;

  // AXI write path: address and data taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= timer_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read path: one cycle to answer
  logic [timer_pkg::DATA_W-1:0] rd_value;
  logic                         rd_mapped;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_value  = '0;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      timer_pkg::OFS_CTRL: begin
        rd_value[timer_pkg::CTRL_ON_BIT]                             = timer_on_bit;
        rd_value[timer_pkg::CTRL_SRC_LSB +: 2]                       = count_source;
        rd_value[timer_pkg::CTRL_PS_LSB +: timer_pkg::PS_SEL_W]      = prescale_select;
        rd_value[timer_pkg::CTRL_SYNC_BIT]                           = ext_sync_en;
        rd_value[timer_pkg::CTRL_PIN_LSB +: timer_pkg::PIN_SEL_W]    = ext_count_pin_select;
      end
      timer_pkg::OFS_COUNT_LO: rd_value[7:0] = count[7:0];
      timer_pkg::OFS_COUNT_HI: rd_value[7:0] = count[15:8];
      timer_pkg::OFS_STATUS: begin
        rd_value[timer_pkg::STAT_ARMED_BIT] = armed;
        rd_value[timer_pkg::STAT_LEVEL_BIT] = src_level;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= timer_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_mapped ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sys_four_a: assert property (
      (timer_on_bit && count_source == timer_pkg::SRC_SYS && prescale_select == 2'h0 &&
       !count_wr)[*4] |=> count == $past(count, 4) + 16'h0004)
    else $error("system clock source did not add four per instruction cycle");
  arm_first_a: assert property (
      (edge_source && !armed && !count_wr) |=> count == $past(count))
    else $error("counted before a falling edge");
  disarm_off_a: assert property (!timer_on_bit |=> !armed)
    else $error("disabled counter stayed armed");
  write_disarm_a: assert property (count_wr |=> !armed)
    else $error("count write left the counter armed");
  pin_rise_a: assert property (
      (timer_on_bit && count_source == timer_pkg::SRC_PIN && armed && src_rise &&
       prescale_select == 2'h0 && !count_wr) |=> count == $past(count) + 16'h0001)
    else $error("pin rising edge not counted");
  sec_rise_a: assert property (
      (timer_on_bit && count_source == timer_pkg::SRC_SEC && armed && src_rise &&
       prescale_select == 2'h0 && !count_wr) |=> count == $past(count) + 16'h0001)
    else $error("secondary oscillator edge not counted");
  sync_stage_a: assert property (
      (ext_sync_en && $stable(ext_sync_en) && $stable(count_source) &&
       $stable(ext_count_pin_select)) |-> src_level == $past(raw_level))
    else $error("synchronised source not delayed one clock");
  count_wrap_a: assert property (
      (count == timer_pkg::COUNT_MAX && inc && !count_wr) |=> count == 16'h0000)
    else $error("count did not wrap to zero");
  byte_write_a: assert property (wr_lo |=> count[7:0] == $past(w_data[7:0]))
    else $error("low byte write lost");
  write_resp_a: assert property (do_write |=> s_axi_bvalid)
    else $error("write response missing");

  count_wrap_c: cover property (count == timer_pkg::COUNT_MAX && inc);
  pin_count_c:  cover property (count_source == timer_pkg::SRC_PIN && inc);
  sec_count_c:  cover property (count_source == timer_pkg::SRC_SEC && inc);
  rewrite_c:    cover property (count_wr && armed);
endmodule
`default_nettype wire

// ---- common/timer_pkg.sv ----
// Constants and types shared by the prescaled timer/counter design
`default_nettype none
package timer_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_COUNT_LO  = 8'h04;
  localparam logic [7:0]  OFS_COUNT_HI  = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  // Control register fields and reset value
  localparam int unsigned CTRL_ON_BIT   = 0;
  localparam int unsigned CTRL_SRC_LSB  = 1;
  localparam int unsigned CTRL_PS_LSB   = 4;
  localparam int unsigned CTRL_SYNC_BIT = 6;
  localparam int unsigned CTRL_PIN_LSB  = 8;
  localparam logic [9:0]  CTRL_RESET    = 10'h000;
  // Status register fields
  localparam int unsigned STAT_ARMED_BIT = 0;
  localparam int unsigned STAT_LEVEL_BIT = 1;
  // Counter geometry
  localparam int unsigned COUNT_W       = 16;
  localparam int unsigned BYTE_W        = 8;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  // Prescaler geometry
  localparam int unsigned PS_SEL_W      = 2;
  localparam int unsigned PS_CNT_W      = 3;
  // External pin choices
  localparam int unsigned PIN_COUNT     = 4;
  localparam int unsigned PIN_SEL_W     = 2;
  // System clocks per instruction cycle, minus one
  localparam logic [1:0]  INSTR_LAST    = 2'h3;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    SRC_SYS   = 2'b00,
    SRC_PIN   = 2'b01,
    SRC_SEC   = 2'b10,
    SRC_INSTR = 2'b11
  } source_t;
endpackage
`default_nettype wire

// ---- common/count_if.sv ----
// Carrier between the counter control logic and the prescaler
`default_nettype none
interface count_if;
  logic                             tick;
  logic                             clear;
  logic [timer_pkg::PS_SEL_W-1:0]   select;
  logic                             tick_out;

  modport feeder  (output tick, output clear, output select, input tick_out);
  modport divider (input tick, input clear, input select, output tick_out);
endinterface
`default_nettype wire

// ---- verilog/bit_sync.sv ----
// Two flip-flop synchroniser for a group of asynchronous levels
`default_nettype none
module bit_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/count_prescaler.sv ----
// Divide-by-1/2/4/8 prescaler, cleared on demand, not visible to software
`default_nettype none
module count_prescaler (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Tick path
  count_if.divider  ps
);
  logic [timer_pkg::PS_CNT_W-1:0] cnt;
  logic [timer_pkg::PS_CNT_W-1:0] limit;
  logic [timer_pkg::PS_CNT_W-1:0] next_cnt;
  logic                           at_limit;

  // Divide ratio is two to the power of the select field
  assign limit    = timer_pkg::PS_CNT_W'((4'h1 << ps.select) - 4'h1);
  // A count left above a newly lowered limit ticks at once instead of wrapping
  assign at_limit = (cnt >= limit);
  assign ps.tick_out = ps.tick && at_limit && !ps.clear;
  assign next_cnt = ps.clear ? '0 :
                    !ps.tick ? cnt :
                    at_limit ? '0 : cnt + 3'h1;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  ps_clear_a: assert property (ps.clear |=> cnt == 3'h0)
    else $error("prescale count not cleared");
  ps_ratio_a: assert property ((ps.tick && !ps.clear && ps.select == 2'h3 && cnt == 3'h6)
                               |=> (ps.tick && !ps.clear) |-> ps.tick_out)
    else $error("divide by eight did not tick on eighth input");
  ps_hold_a: assert property (!ps.tick |-> !ps.tick_out)
    else $error("prescaler ticked without input");
  ps_div8_c: cover property (ps.tick_out && ps.select == 2'h3);
endmodule
`default_nettype wire

// ---- testbench/ext_pulse_source.sv ----
// Model of the external count pins and the free-running secondary oscillator
`default_nettype none
module ext_pulse_source #(
  parameter int unsigned SEC_HALF = 5
) (
  // Clock
  input  wire logic       clock_i,
  // Pin choice
  input  wire logic [1:0] pin_sel_i,
  // Driven lines
  output logic      [3:0] pins_o,
  output logic            sec_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        level   = 1'b1;
  logic        pattern = 1'b0;
  logic        sec_lvl = 1'b0;
  int unsigned sec_cnt = 0;

  // Oscillator runs free; unselected pins toggle every cycle
  always @(posedge clock_i) begin
    pattern <= ~pattern;
    if (sec_cnt == SEC_HALF - 1) begin
      sec_cnt <= 0;
      sec_lvl <= ~sec_lvl;
    end else begin
      sec_cnt <= sec_cnt + 1;
    end
  end
  assign sec_o = sec_lvl;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins_o[i] = (i == int'(pin_sel_i)) ? level : pattern ^ i[0];
    end
  end

  // Level changes are made on a rising edge of clock_i, the system clock
  task automatic drive(input logic v);
    @(posedge clock_i);
    level <= v;
  endtask

  // Each pulse is a low phase then a high phase, both w cycles wide
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      drive(1'b0);
      repeat (w - 1) @(posedge clock_i);
      drive(1'b1);
      repeat (w - 1) @(posedge clock_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the prescaled timer/counter
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_CTRL = timer_pkg::OFS_CTRL;
  localparam logic [7:0] A_LO   = timer_pkg::OFS_COUNT_LO;
  localparam logic [7:0] A_HI   = timer_pkg::OFS_COUNT_HI;
  localparam logic [7:0] A_STAT = timer_pkg::OFS_STATUS;
  localparam logic [1:0] OK     = timer_pkg::RESP_OKAY;
  localparam logic [1:0] ERR    = timer_pkg::RESP_SLVERR;
  logic        clock = 1'b0, resetn = 1'b0, sec_in, sec_clk, sync_on = 1'b0;
  logic [3:0]  pins, wstrb = 4'h0, strb = 4'h3;
  logic [2:0]  prot = 3'h0;
  logic [1:0]  pin_sel = 2'h0, bresp, rresp;
  logic [15:0] count;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        s1, s2;
  int          miscompares = 0, n_checks = 0;

  always #10 clock = ~clock;

  ext_pulse_source src (.clock_i(clock), .pin_sel_i(pin_sel), .pins_o(pins), .sec_o(sec_in));
  prescaled_timer_counter uut (
    .clock_i(clock), .resetn_i(resetn), .ext_count_input_i(pins), .secondary_osc_in_i(sec_in),
    .secondary_osc_clk_o(sec_clk), .count_value_o(count),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp)
  );

  task automatic end_of_test();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    miscompares++;
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d; wstrb <= strb; bready <= 1'b1;
    prot <= 3'($urandom);
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) timeout();
    check({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clock);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    prot <= 3'($urandom);
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    if (n >= 100) timeout();
    check({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic wait_change(output int t);
    logic [15:0] prev;
    prev = count;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (count === prev && t < 200);
    if (t >= 200) timeout();
  endtask

  function automatic logic [31:0] ctrl_word(input logic on, input logic [1:0] s,
                                            input logic [1:0] ps, input logic sy,
                                            input logic [1:0] pin);
    return {22'h0, pin, 1'b0, sy, ps, 1'b0, s, on};
  endfunction

  function automatic int spacing_of(input logic [1:0] s, input logic [1:0] ps);
    return ((s == timer_pkg::SRC_INSTR) ? 4 : 1) << ps;
  endfunction

  // Synchronised secondary clock is the input two cycles late
  always @(posedge clock) begin
    s1 <= sec_in;
    s2 <= s1;
    if (sync_on) check({31'h0, sec_clk}, {31'h0, s2});
  end

  initial begin
    logic [31:0] d, r;
    logic [15:0] nxt;
    logic [1:0]  s;
    int          t, n, w, seed;
    seed = $urandom(32'hd2b90f01);
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    sync_on <= 1'b1;
    rd(A_CTRL, OK, d); check(d, 32'h0);
    rd(A_LO, OK, d); check(d, 32'h0);
    rd(A_STAT, OK, d); check(d & 32'hfffffffd, 32'h0);
    rd(8'h10, ERR, d); check(d, 32'h0);
    wr(8'h14, 32'h1, ERR);
    wr(A_STAT, 32'hffffffff, OK);
    rd(A_STAT, OK, d); check(d & 32'hfffffffd, 32'h0);
    r = $urandom & 32'hfffffffe;
    wr(A_CTRL, r, OK);
    rd(A_CTRL, OK, d); check(d, r & 32'h377);
    // Upper strobe alone moves only the pin choice
    strb = 4'h2;
    wr(A_CTRL, ~r, OK);
    strb = 4'h3;
    rd(A_CTRL, OK, d); check(d, (r & 32'h077) | (~r & 32'h300));
    wr(A_CTRL, 32'h0, OK);
    wr(A_HI, 32'hab, OK); wr(A_LO, 32'hcd, OK);
    rd(A_HI, OK, d); check(d, 32'hab);
    check({16'h0, count}, 32'habcd);
    // Step spacing for the system and instruction clock sources at every prescale, wrapping past the top
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? timer_pkg::SRC_SYS : timer_pkg::SRC_INSTR;
      wr(A_CTRL, 32'h0, OK); wr(A_HI, 32'hff, OK); wr(A_LO, 32'hfd, OK);
      wr(A_CTRL, ctrl_word(1'b1, s, i[1:0], 1'b0, 2'h0), OK);
      wait_change(t);
      repeat (3) begin
        nxt = count + 16'h1;
        wait_change(t);
        check(t, spacing_of(s, i[1:0]));
        check({16'h0, count}, {16'h0, nxt});
      end
    end
    // Byte writes closer than the prescale period keep the count frozen
    wr(A_CTRL, ctrl_word(1'b1, timer_pkg::SRC_SYS, 2'h3, 1'b0, 2'h0), OK);
    for (int i = 0; i < 8; i++) begin
      wr(i[0] ? A_HI : A_LO, i[0] ? 32'h12 : 32'h55, OK);
      @(posedge clock);
      if (i > 0) check({16'h0, count}, 32'h1255);
    end
    wait_change(t);
    check({31'h0, t <= 10}, 32'h1);
    // Pin counting, armed only by a falling edge
    for (int k = 0; k < 2; k++) begin
      pin_sel <= 2'($urandom);
      n = 2 + $urandom % 4;
      w = 3 + $urandom % 4;
      src.drive(1'b0);
      wr(A_CTRL, ctrl_word(1'b1, timer_pkg::SRC_PIN, 2'h0, k[0], pin_sel), OK);
      wr(A_HI, 32'h0, OK); wr(A_LO, 32'h0, OK);
      src.drive(1'b1);
      repeat (8) @(posedge clock);
      check({16'h0, count}, 32'h0);
      src.pulses(n, w);
      repeat (8) @(posedge clock);
      check({16'h0, count}, n);
      d = ctrl_word(1'b1, timer_pkg::SRC_PIN, 2'h0, 1'b0, pin_sel);
      wr(A_CTRL, d & 32'hfffffffe, OK);
      src.drive(1'b0);
      repeat (8) @(posedge clock);
      wr(A_CTRL, d, OK);
      src.drive(1'b1);
      repeat (8) @(posedge clock);
      check({16'h0, count}, n);
      src.pulses(1, w);
      repeat (8) @(posedge clock);
      check({16'h0, count}, n + 1);
    end
    // Secondary oscillator as count source
    wr(A_CTRL, ctrl_word(1'b1, timer_pkg::SRC_SEC, 2'h0, 1'b0, 2'h0), OK);
    wr(A_LO, 32'h0, OK);
    repeat (200) @(posedge clock);
    check({31'h0, (count >= 16'd18) && (count <= 16'd20)}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
